// file: tds_defs.svh
// constants for the distortion alarm supervisor: offsets, resets, timing
// assumes a 200 MHz clock and 32-bit apb with byte addresses
`ifndef TDS_DEFS_SVH
`define TDS_DEFS_SVH
`define TDS_CLK_MHZ       200
`define TDS_CYCLE_MS      5
`define TDS_CYCLE_CLKS    (`TDS_CYCLE_MS * `TDS_CLK_MHZ * 1000)
`define TDS_BLK_LEAD_MS   5
`define TDS_DLY_STEP_MS   5
`define TDS_DLY_MAX_MS    1800000
`define TDS_DLY_MAX       19'(`TDS_DLY_MAX_MS / `TDS_DLY_STEP_MS)
`define TDS_DLY_DEF_MS    10000
`define TDS_DLY_RST       19'(`TDS_DLY_DEF_MS / `TDS_DLY_STEP_MS)
`define TDS_PU_RST        16'h03e8
`define TDS_REL_PCT       32'd97
`define TDS_FULL_PCT      32'd100
`define TDS_LOG_DEPTH     12
`define TDS_EVSEL_RST     6'h3f
`define TDS_A_CTRL        8'h00
`define TDS_A_PICKUP      8'h04
`define TDS_A_DELAY       8'h08
`define TDS_A_EVSEL       8'h0c
`define TDS_A_STATUS      8'h10
`define TDS_A_ISTAT       8'h14
`define TDS_A_IMASK       8'h18
`define TDS_A_CNT0        8'h1c
`define TDS_A_CNT1        8'h20
`define TDS_A_CNT2        8'h24
`define TDS_A_LOGSEL      8'h28
`define TDS_A_LOGSTAMP    8'h2c
`define TDS_A_LOGINFO     8'h30
`define TDS_A_LOGL12      8'h34
`define TDS_A_LOGL3       8'h38
`define TDS_CTRL_EN       0
`define TDS_CTRL_CLR      1
`define TDS_CTRL_MODE     4:2
`define TDS_EV_S_ON       0
`define TDS_EV_A_ON       2
`define TDS_EV_B_ON       4
`endif

// file: tds_pkg.sv
// types shared by the distortion alarm supervisor
// assumes tds_defs.svh holds all numbers
package tds_pkg;
    typedef enum logic [2:0] {
        TDS_ON, TDS_BLK, TDS_TEST, TDS_TESTBLK, TDS_OFF
    } tds_mode_t;
    typedef enum logic [1:0] {
        TDS_NORMAL, TDS_START, TDS_ALARM, TDS_BLOCKED
    } tds_cond_t;
    // fire bits: start on/off, alarm on/off, blocked on/off
    typedef struct packed {
        logic [5:0]  fire;
        logic [31:0] stamp;
    } tds_evt_t;
    typedef struct packed {
        logic [31:0]      stamp;
        logic [1:0]       id;
        logic [2:0]       grp;
        logic [2:0][15:0] thd;
    } tds_log_t;
endpackage

// file: tds_supervisor.sv
// distortion alarm supervisor: pick-up, blocking, delay, events, log
// assumes phase distortion in 0.01 % units, synchronous inputs, apb master
`timescale 1ns/1ps
`include "tds_defs.svh"

// Behaviour
// - blocking input sampled once per processing cycle, used for all decisions
// - pick-up without blocking asserts start and runs the alarm timer
// - pick-up with blocking asserts blocked, no timing and no alarm
// - blocking during start drops start, timer released as on reset
// - definite delay 0..1800 s in 5 ms steps, default 10 s
// - condition reads normal, start, alarm or blocked
// - behaviour reads on, blocked, test, test-blocked or off
// - timestamped on/off events, per event selection of on, off, both
// - clearable cumulative counts of start, alarm and blocked
// - each on event written into rolling log of twelve records
// - pick-up releases below 97 percent of the setting
// - pick-up when any phase exceeds the common threshold, default 10 %
// - alarm only while alarm enable is set
module tds_supervisor
    import tds_pkg::*;
#(
    parameter int unsigned CYCLE_CLKS = `TDS_CYCLE_CLKS
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             block_req,
    input  wire logic [2:0][15:0] phase_thd,
    input  wire logic [2:0]       set_group,
    output logic                  start_out,
    output logic                  alarm_out,
    output logic                  blocked_out,
    output tds_cond_t             cond,
    output tds_evt_t              evt,
    output logic                  irq
);
    localparam int LD = `TDS_LOG_DEPTH;

    logic [31:0]      div_q, div_d, stamp_q, stamp_d;
    logic             tick, blk_now, off, over, below;
    logic             pu_q, pu_d, st_q, st_d, al_q, al_d, bk_q, bk_d;
    logic [18:0]      el_q, el_d;
    logic [5:0]       ev;
    tds_cond_t        cond_q, cond_d;
    tds_evt_t         evt_q, evt_d;
    logic [2:0][15:0] cnt_q, cnt_d;
    tds_log_t [LD-1:0] log_q, log_d;
    logic [3:0]       wp_q, wp_d, wp2;
    logic             first, second;
    logic [1:0]       fid;

    // bus side registers
    logic             en_q, en_d;
    tds_mode_t        mode_q, mode_d;
    logic [15:0]      thr_q, thr_d;
    logic [18:0]      dly_q, dly_d;
    logic [5:0]       sel_q, sel_d, ist_q, ist_d, msk_q, msk_d;
    logic [3:0]       lsel_q, lsel_d;
    logic [31:0]      rd_q, rd_d;
    logic             rdy_q, rdy_d, err_q, err_d, irq_q, irq_d;
    logic             acc, wr, rd, clr;

    // rel=0: above threshold; rel=1: below 97 % of threshold
    function automatic logic thd_cmp(logic [15:0] v, logic [15:0] t,
                                     logic rel);
        if (rel)
            return (32'(v) * `TDS_FULL_PCT) < (32'(t) * `TDS_REL_PCT);
        return v > t;
    endfunction

    function automatic logic [3:0] wrap_inc(logic [3:0] p);
        return (p == 4'(LD - 1)) ? 4'h0 : p + 4'h1;
    endfunction

    function automatic logic hit(logic [7:0] a);
        return a <= `TDS_A_LOGL3 && a[1:0] == 2'h0;
    endfunction

    assign tick = (div_q == 32'(CYCLE_CLKS - 1));

    always_comb begin
        div_d   = tick ? 32'h0 : div_q + 32'h1;
        stamp_d = tick ? stamp_q + 32'h1 : stamp_q;
        blk_now = block_req || mode_q == TDS_BLK || mode_q == TDS_TESTBLK;
        off     = mode_q == TDS_OFF;
        over    = 1'b0;
        below   = 1'b1;
        for (int p = 0; p < 3; p++) begin
            over  = over | thd_cmp(phase_thd[p], thr_q, 1'b0);
            below = below & thd_cmp(phase_thd[p], thr_q, 1'b1);
        end
        pu_d = pu_q;
        st_d = st_q;
        al_d = al_q;
        bk_d = bk_q;
        el_d = el_q;
        if (tick) begin
            pu_d = !off && (over || (pu_q && !below));
            st_d = pu_d && !blk_now;
            bk_d = pu_d && blk_now;
            el_d = !st_d ? 19'h0 :
                   (st_q && el_q < dly_q) ? el_q + 19'h1 : el_q;
            // definite delay in 5 ms steps
            // continuous start for the full delay
            al_d = st_d && en_q && el_d >= dly_q;
        end
        ev = {bk_q & ~bk_d, bk_d & ~bk_q, al_q & ~al_d,
              al_d & ~al_q, st_q & ~st_d, st_d & ~st_q};
        evt_d.fire  = ev & sel_q;
        evt_d.stamp = stamp_q;
        cond_d = al_d ? TDS_ALARM : st_d ? TDS_START :
                 bk_d ? TDS_BLOCKED : TDS_NORMAL;
        for (int k = 0; k < 3; k++) begin
            cnt_d[k] = (clr ? 16'h0 : cnt_q[k]) + 16'(ev[2 * k]);
        end
        // up to two records per cycle into the rolling log
        first  = ev[`TDS_EV_S_ON] | ev[`TDS_EV_B_ON];
        second = ev[`TDS_EV_A_ON];
        fid    = ev[`TDS_EV_S_ON] ? 2'h0 : 2'h2;
        wp2    = first ? wrap_inc(wp_q) : wp_q;
        log_d  = log_q;
        for (int i = 0; i < LD; i++) begin
            if (first && wp_q == 4'(i))
                log_d[i] = '{stamp_q, fid, set_group, phase_thd};
            if (second && wp2 == 4'(i))
                log_d[i] = '{stamp_q, 2'h1, set_group, phase_thd};
        end
        wp_d = second ? wrap_inc(wp2) : wp2;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q   <= 32'h0;
            stamp_q <= 32'h0;
            pu_q    <= 1'b0;
            st_q    <= 1'b0;
            al_q    <= 1'b0;
            bk_q    <= 1'b0;
            el_q    <= 19'h0;
            cond_q  <= TDS_NORMAL;
            evt_q   <= '0;
            cnt_q   <= '0;
            log_q   <= '0;
            wp_q    <= 4'h0;
        end else begin
            div_q   <= div_d;
            stamp_q <= stamp_d;
            pu_q    <= pu_d;
            st_q    <= st_d;
            al_q    <= al_d;
            bk_q    <= bk_d;
            el_q    <= el_d;
            cond_q  <= cond_d;
            evt_q   <= evt_d;
            cnt_q   <= cnt_d;
            log_q   <= log_d;
            wp_q    <= wp_d;
        end
    end

    // zero-wait slave: data is prepared in setup, so pready comes from a flop
    assign acc = psel && penable && rdy_q;
    assign wr  = acc && pwrite && !err_q;
    assign rd  = acc && !pwrite;
    assign clr = wr && paddr == `TDS_A_CTRL && pwdata[`TDS_CTRL_CLR];

    always_comb begin
        en_d   = en_q;
        mode_d = mode_q;
        thr_d  = thr_q;
        dly_d  = dly_q;
        sel_d  = sel_q;
        msk_d  = msk_q;
        lsel_d = lsel_q;
        if (wr) begin
            case (paddr)
                `TDS_A_CTRL: begin
                    en_d = pwdata[`TDS_CTRL_EN];
                    if (pwdata[`TDS_CTRL_MODE] <= 3'(TDS_OFF))
                        mode_d = tds_mode_t'(pwdata[`TDS_CTRL_MODE]);
                end
                `TDS_A_PICKUP: thr_d = pwdata[15:0];
                `TDS_A_DELAY: begin
                    if (pwdata[18:0] <= `TDS_DLY_MAX)
                        dly_d = pwdata[18:0];
                end
                `TDS_A_EVSEL: sel_d = pwdata[5:0];
                `TDS_A_IMASK: msk_d = pwdata[5:0];
                `TDS_A_LOGSEL: begin
                    if (pwdata[3:0] < 4'(LD))
                        lsel_d = pwdata[3:0];
                end
                default: ;
            endcase
        end
        // read clears status; a same-cycle event still sets its bit
        ist_d = ((rd && paddr == `TDS_A_ISTAT) ? 6'h0 : ist_q) | ev;
        irq_d = |(ist_d & msk_d);
        rdy_d = psel && !penable;
        err_d = psel && !penable && !hit(paddr);
        rd_d  = 32'h0;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `TDS_A_CTRL: rd_d = {27'h0, 3'(mode_q), 1'b0, en_q};
                `TDS_A_PICKUP: rd_d = {16'h0, thr_q};
                `TDS_A_DELAY: rd_d = {13'h0, dly_q};
                `TDS_A_EVSEL: rd_d = {26'h0, sel_q};
                // behaviour shows the node operating mode
                `TDS_A_STATUS: rd_d = {26'h0, pu_q, 3'(mode_q), cond_q};
                `TDS_A_ISTAT: rd_d = {26'h0, ist_q};
                `TDS_A_IMASK: rd_d = {26'h0, msk_q};
                `TDS_A_CNT0: rd_d = {16'h0, cnt_q[0]};
                `TDS_A_CNT1: rd_d = {16'h0, cnt_q[1]};
                `TDS_A_CNT2: rd_d = {16'h0, cnt_q[2]};
                `TDS_A_LOGSEL: rd_d = {24'h0, wp_q, lsel_q};
                `TDS_A_LOGSTAMP: rd_d = log_q[lsel_q].stamp;
                `TDS_A_LOGINFO:
                    rd_d = {27'h0, log_q[lsel_q].grp, log_q[lsel_q].id};
                `TDS_A_LOGL12:
                    rd_d = {log_q[lsel_q].thd[1], log_q[lsel_q].thd[0]};
                `TDS_A_LOGL3: rd_d = {16'h0, log_q[lsel_q].thd[2]};
                default: rd_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            en_q   <= 1'b1;
            mode_q <= TDS_ON;
            thr_q  <= `TDS_PU_RST;
            dly_q  <= `TDS_DLY_RST;
            sel_q  <= `TDS_EVSEL_RST;
            msk_q  <= 6'h0;
            lsel_q <= 4'h0;
            ist_q  <= 6'h0;
            irq_q  <= 1'b0;
            rdy_q  <= 1'b0;
            err_q  <= 1'b0;
            rd_q   <= 32'h0;
        end else begin
            en_q   <= en_d;
            mode_q <= mode_d;
            thr_q  <= thr_d;
            dly_q  <= dly_d;
            sel_q  <= sel_d;
            msk_q  <= msk_d;
            lsel_q <= lsel_d;
            ist_q  <= ist_d;
            irq_q  <= irq_d;
            rdy_q  <= rdy_d;
            err_q  <= err_d;
            rd_q   <= rd_d;
        end
    end

    assign prdata      = rd_q;
    assign pready      = rdy_q;
    assign pslverr     = err_q;
    assign start_out   = st_q;
    assign alarm_out   = al_q;
    assign blocked_out = bk_q;
    assign cond        = cond_q;
    assign evt         = evt_q;
    assign irq         = irq_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    once_per_cycle_a: assert property (
        $changed({st_q, bk_q, al_q}) |-> $past(tick))
        else $error("state moved outside a processing cycle");
    start_unblocked_a: assert property (
        $rose(st_q) |-> $past(!blk_now && pu_d) && el_q == 19'h0)
        else $error("start without clean pick-up");
    blocked_quiet_a: assert property (
        bk_q |-> !st_q && !al_q && el_q == 19'h0)
        else $error("blocked state still timing");
    block_drops_a: assert property (
        tick && st_q && blk_now |=> !st_q && !al_q && el_q == 19'h0)
        else $error("blocking did not drop start");
    delay_reached_a: assert property (
        $rose(al_q) |-> el_q >= dly_q && st_q)
        else $error("alarm before delay");
    cond_code_a: assert property (
        (cond_q == TDS_ALARM) == al_q && (al_q || st_q || bk_q ||
        cond_q == TDS_NORMAL))
        else $error("condition mismatch");
    event_sel_a: assert property (
        evt_q.fire[0] |-> st_q && $past(!st_q) && $past(sel_q[0]))
        else $error("start on event without edge");
    count_step_a: assert property (
        $rose(st_q) && !$past(clr) |-> cnt_q[0] == $past(cnt_q[0]) + 16'h1)
        else $error("start count not advanced");
    log_advance_a: assert property (
        $rose(bk_q) |-> wp_q != $past(wp_q) && log_q[$past(wp_q)].id == 2'h2)
        else $error("blocked record missing");
    release_hyst_a: assert property (
        $fell(pu_q) && !$past(off) |-> $past(below))
        else $error("pick-up released above hysteresis");
    alarm_enable_a: assert property (
        !en_q |=> !$rose(al_q))
        else $error("alarm while disabled");
    alarm_start_a: assert property (
        al_q |-> st_q)
        else $error("alarm without start");
    irq_level_a: assert property (
        irq_q == |(ist_q & msk_q))
        else $error("interrupt level wrong");

    alarm_seen_c: cover property ($rose(al_q));
    block_in_start_c: cover property (st_q ##1 bk_q);
    log_wrap_c: cover property (wp_q == 4'(LD - 1) ##1 wp_q == 4'h0);
endmodule

// file: tds_blk_src.sv
// blocking source standing in for the relay's blocking matrix
// assumes one clock; the request moves only just after a rising edge
`timescale 1ns/1ps
module tds_blk_src (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic want,
    output logic      block_req
);
    logic block_d, block_q;
    // bench raises want a tick before expiry
    always_comb block_d = want;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            block_q <= 1'b0;
        else
            block_q <= block_d;
    end
    assign block_req = block_q;
endmodule

// file: test_thd_alarm_supervisor.sv
// bench for the distortion supervisor: apb master, pick-up, blocking
// assumes tds_supervisor and tds_blk_src; tick shortened to CYC clocks
`timescale 1ns/1ps
`include "tds_defs.svh"
module test_thd_alarm_supervisor
    import tds_pkg::*;
;
    localparam int CYC = 20;
    localparam int DLY = 3;
    logic             clk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic             want, block_req, start_out, alarm_out, blocked_out;
    logic             irq, err_v, clr_fire, flag;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata, rd_v;
    logic [2:0][15:0] phase_thd;
    logic [2:0]       set_group;
    logic [5:0]       fire_seen;
    logic [15:0]      lfsr_q, hi;
    tds_cond_t        cond;
    tds_evt_t         evt;
    int               fail_count, total_checks, n, m_cnt[3];
    int               clk_n, st_stamp;
    int               rec_q[$];
    tds_blk_src blk_u (.clk(clk), .arst_n(arst_n), .want(want),
                       .block_req(block_req));
    tds_supervisor #(.CYCLE_CLKS(CYC)) dut_u (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .block_req(block_req),
        .phase_thd(phase_thd), .set_group(set_group), .irq(irq),
        .start_out(start_out), .alarm_out(alarm_out), .cond(cond),
        .blocked_out(blocked_out), .evt(evt));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // sticky record of event pulses since the last clear
    always @(posedge clk)
        fire_seen <= clr_fire ? 6'h00 : fire_seen | evt.fire;
    // clocks since reset release, the tick count model for stamps
    always @(posedge clk)
        clk_n <= arst_n ? clk_n + 1 : 0;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic outv(input int w);
        return w == 0 ? start_out : w == 1 ? alarm_out : blocked_out;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t %s: %h not %h", $time, msg, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no cycle count assumed; only the watchdog ends a stuck wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input string msg);
        apb(1'b0, a, 32'h0);
        chk(rd_v, e, msg);
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge clk);
    endtask
    // bounded wait; the caller compares the level afterwards
    task automatic wait_out(input int w, input logic v);
        for (int k = 0; k < 10 * CYC && outv(w) !== v; k++)
            @(posedge clk);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // run is near 1000 clocks; forty times that means a hang
    initial begin
        #200000;
        fail_count++;
        close_out();
    end
    initial begin
        arst_n = 1'b0;
        {psel, penable, pwrite, want, clr_fire} = 5'h01;
        {paddr, pwdata, phase_thd} = '0;
        lfsr_q = lfsr(16'h0b26);
        hi = 16'h03e9 + lfsr_q % 16'h01f4;
        set_group = 3'(lfsr(lfsr_q));
        fail_count = 0;
        total_checks = 0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        clr_fire <= 1'b0;
        rdc(`TDS_A_CTRL, 32'h1, "ctrl");
        rdc(`TDS_A_PICKUP, 32'h3e8, "pickup");
        rdc(`TDS_A_DELAY, 32'h7d0, "delay");
        rdc(`TDS_A_EVSEL, 32'h3f, "evsel");
        rdc(`TDS_A_IMASK, 32'h0, "imask");
        apb(1'b0, 8'h3c, 32'h0);
        chk(err_v, 1'b1, "unmapped err");
        chk(rd_v, 32'h0, "unmapped data");
        apb(1'b1, `TDS_A_DELAY, 32'h57e40);
        apb(1'b1, `TDS_A_DELAY, 32'h57e41);
        rdc(`TDS_A_DELAY, 32'h57e40, "delay max");
        apb(1'b1, `TDS_A_DELAY, DLY);
        phase_thd <= {16'h0, 16'h0, 16'h03e8};
        wt(3 * CYC);
        chk(start_out, 1'b0, "at threshold");
        phase_thd <= {16'h0, 16'h0, hi};
        wait_out(0, 1'b1);
        chk(start_out, 1'b1, "start");
        chk(cond, TDS_START, "cond start");
        chk(evt.fire, 6'h01, "start event");
        st_stamp = clk_n / CYC - 1;
        chk(evt.stamp, st_stamp, "start stamp");
        m_cnt[0]++;
        rec_q.push_back(0);
        for (n = 0; n < 400 && alarm_out !== 1'b1; n++)
            @(posedge clk);
        chk(n, DLY * CYC, "alarm delay");
        chk(cond, TDS_ALARM, "cond alarm");
        m_cnt[1]++;
        rec_q.push_back(1);
        chk(irq, 1'b0, "masked irq");
        apb(1'b1, `TDS_A_IMASK, 32'h3f);
        wt(2);
        chk(irq, 1'b1, "irq");
        rdc(`TDS_A_ISTAT, 32'h05, "istat on");
        wt(2);
        chk(irq, 1'b0, "irq clear");
        phase_thd <= {3{16'h03ca}};
        wt(3 * CYC);
        chk(alarm_out, 1'b1, "hold");
        phase_thd <= {3{16'h03c9}};
        wait_out(0, 1'b0);
        chk(alarm_out, 1'b0, "alarm off");
        chk(cond, TDS_NORMAL, "cond normal");
        rdc(`TDS_A_ISTAT, 32'h0a, "istat off");
        want <= 1'b1;
        wt(2 * CYC);
        phase_thd <= {3{hi}};
        flag = 1'b0;
        repeat ((DLY + 2) * CYC) begin
            @(posedge clk);
            if (start_out !== 1'b0 || alarm_out !== 1'b0)
                flag = 1'b1;
        end
        chk(flag, 1'b0, "start blocked");
        chk(blocked_out, 1'b1, "blocked");
        chk(cond, TDS_BLOCKED, "cond blocked");
        m_cnt[2]++;
        rec_q.push_back(2);
        for (n = 0; n < 3; n++)
            rdc(8'(`TDS_A_CNT0 + 4 * n), m_cnt[n], "count");
        apb(1'b0, `TDS_A_LOGSEL, 32'h0);
        chk(rd_v[7:4], rec_q.size() % `TDS_LOG_DEPTH, "slot");
        apb(1'b1, `TDS_A_LOGSEL, 32'(rec_q.size() - 1));
        rdc(`TDS_A_LOGINFO, {set_group, 2'(rec_q[$])}, "log id");
        rdc(`TDS_A_LOGL3, hi, "log thd");
        apb(1'b1, `TDS_A_LOGSEL, 32'h0);
        rdc(`TDS_A_LOGSTAMP, st_stamp, "log stamp");
        rdc(`TDS_A_LOGL12, {16'h0, hi}, "log l12");
        apb(1'b1, `TDS_A_CTRL, 32'h3);
        rdc(`TDS_A_CNT0, 32'h0, "count clear");
        phase_thd <= '0;
        want <= 1'b0;
        wt(2 * CYC);
        phase_thd <= {hi, hi, 16'h0};
        wait_out(0, 1'b1);
        // pulse kept clear of the next tick, so it must go unseen
        wt(5);
        want <= 1'b1;
        wt(5);
        want <= 1'b0;
        wt(CYC);
        chk(start_out, 1'b1, "pulse unseen");
        want <= 1'b1;
        wait_out(0, 1'b0);
        chk(start_out, 1'b0, "start drop");
        wt(DLY * CYC);
        chk(alarm_out, 1'b0, "no alarm");
        want <= 1'b0;
        wait_out(0, 1'b1);
        chk(start_out, 1'b1, "restart");
        apb(1'b1, `TDS_A_CTRL, 32'h0);
        wt((DLY + 2) * CYC);
        chk(alarm_out, 1'b0, "disabled");
        phase_thd <= '0;
        wait_out(0, 1'b0);
        for (n = 0; n < 6; n++) begin
            apb(1'b1, `TDS_A_CTRL, 32'(n << 2 | 1));
            apb(1'b0, `TDS_A_STATUS, 32'h0);
            chk(rd_v[4:2], n > 4 ? 4 : n, "behaviour");
        end
        phase_thd <= {3{hi}};
        wt(3 * CYC);
        chk(start_out, 1'b0, "mode off");
        apb(1'b1, `TDS_A_CTRL, 32'hd);
        wt(2 * CYC);
        chk(blocked_out, 1'b1, "test blocked");
        phase_thd <= '0;
        wait_out(2, 1'b0);
        phase_thd <= '0;
        apb(1'b1, `TDS_A_CTRL, 32'h1);
        apb(1'b0, `TDS_A_ISTAT, 32'h0);
        apb(1'b1, `TDS_A_EVSEL, 32'h02);
        clr_fire <= 1'b1;
        wt(1);
        clr_fire <= 1'b0;
        phase_thd <= {3{hi}};
        wait_out(0, 1'b1);
        phase_thd <= '0;
        wait_out(0, 1'b0);
        wt(2);
        chk(fire_seen, 6'h02, "evsel");
        rdc(`TDS_A_ISTAT, 32'h03, "istat all");
        close_out();
    end
endmodule
